// >>> rtl/dtc_pkg.sv
// Contract
// - Four compare registers read/write, reset all ones
// - Control resets zero; flop, clock, run, mode
// - Normal clock codes pick prescaled, low clock, pin
// - Slow modes allow only codes 000, 100, 111, plus 110 in cascade with b at mode 101
// - Run zero stops and clears; one starts
// - Mode 001 divider, 010 pwm, 011 cascade; 001 and 010 count as 000, width compares are unused
// - Mode 000 timer; second counter 16-bit codes
// - Cascade needs first mode held at 011
// - Cascade: first clock select, second run/flop
// - Upper byte counts first counter overflow
// - Second counter has own control and compares
package dtc_pkg;

	// ********************************
	// Register indices (byte address is four times)
	// ********************************
	localparam logic [5:0] IDX_CTL_A = 6'h16; // Counter a control
	localparam logic [5:0] IDX_CTL_B = 6'h17; // Counter b control
	localparam logic [5:0] IDX_PER_A = 6'h18; // Counter a period compare
	localparam logic [5:0] IDX_PER_B = 6'h19; // Counter b period compare
	localparam logic [5:0] IDX_WID_A = 6'h1a; // Counter a width compare
	localparam logic [5:0] IDX_WID_B = 6'h1b; // Counter b width compare
	localparam logic [5:0] IDX_CFG = 6'h1c; // Prescaler and power mode
	localparam logic [5:0] IDX_STAT = 6'h1d; // Live counts

	// ********************************
	// Reset values and field positions
	// ********************************
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] CMP_RST = 8'hff;
	localparam int CFG_PRESEL_BIT = 0; // Prescaler source select
	localparam int CFG_SLOW_BIT = 1; // Slow or sleep power mode

	// ********************************
	// Clock select codes
	// ********************************
	localparam logic [2:0] CK_DIV11 = 3'h0;
	localparam logic [2:0] CK_DIV7 = 3'h1;
	localparam logic [2:0] CK_DIV5 = 3'h2;
	localparam logic [2:0] CK_DIV3 = 3'h3;
	localparam logic [2:0] CK_LOW = 3'h4;
	localparam logic [2:0] CK_DIV1 = 3'h5;
	localparam logic [2:0] CK_FULL = 3'h6;
	localparam logic [2:0] CK_PIN = 3'h7;

	// ********************************
	// Mode codes
	// ********************************
	localparam logic [2:0] MD_TIMER = 3'h0;
	localparam logic [2:0] MD_DIVOUT = 3'h1;
	localparam logic [2:0] MD_PWM = 3'h2;
	localparam logic [2:0] MD_CASC = 3'h3;
	localparam logic [2:0] MD_T16 = 3'h4;
	localparam logic [2:0] MD_WARM = 3'h5;
	localparam logic [2:0] MD_PWM16 = 3'h6;

	// Prescaler widths
	localparam int DIV_W = 11;
	localparam int LOWDIV_W = 3;

	// Control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic ffc;
		logic [2:0] clk_sel;
		logic run;
		logic [2:0] mode;
	} dtc_ctl_t;

endpackage

// >>> rtl/dtc_count8.sv
`timescale 1ns/10ps
// One 8-bit up counter with compare clear and output flop
module dtc_count8 (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Control
	input wire logic run_in,
	input wire logic tick_in,
	input wire logic wrap_in,
	input wire logic [7:0] limit_in,
	input wire logic ff_init_in,
	// Results
	output logic [7:0] cnt_out,
	output logic roll_out,
	output logic ff_out
);
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic ff_ff;
	logic nxt_ff;
	logic hit;

	// Wrap mode rolls at all ones to act as the low byte of a pair
	assign hit = wrap_in ? (cnt_ff == 8'hff) : (cnt_ff == limit_in);
	assign roll_out = run_in & tick_in & hit;
	assign cnt_out = cnt_ff;
	assign ff_out = ff_ff;

	// Next count and flop
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_ff = ff_ff;
		if (!run_in) begin
			nxt_cnt = 8'h00;
			nxt_ff = ff_init_in;
		end else if (roll_out) begin
			nxt_cnt = 8'h00;
			nxt_ff = ~ff_ff;
		end else if (tick_in) begin
			nxt_cnt = cnt_ff + 8'h01;
		end
	end

	// State registers
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_ff <= 8'h00;
			ff_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			ff_ff <= nxt_ff;
		end
	end
endmodule // dtc_count8

// >>> rtl/dtc_timer.sv
`timescale 1ns/10ps
// Dual 8-bit timer pair with Wishbone register access
module dtc_timer (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// External inputs
	input wire logic low_clk_in,
	input wire logic pin_a_in,
	input wire logic pin_b_in,
	// Timer flop outputs
	output logic ff_a_out,
	output logic ff_b_out
);
	// ********************************
	// Declarations
	// ********************************
	dtc_pkg::dtc_ctl_t ctl_a_ff, nxt_ctl_a; // Counter a control
	dtc_pkg::dtc_ctl_t ctl_b_ff, nxt_ctl_b; // Counter b control
	logic [7:0] per_a_ff, nxt_per_a; // Period compares
	logic [7:0] per_b_ff, nxt_per_b;
	logic [7:0] wid_a_ff, nxt_wid_a; // Width compares
	logic [7:0] wid_b_ff, nxt_wid_b;
	logic [1:0] cfg_ff, nxt_cfg; // Prescaler select, slow mode
	logic ack_ff, nxt_ack; // Bus answer
	logic [31:0] dat_ff, nxt_dat; // Read data
	logic [5:0] idx; // Word index
	logic wr_en; // Write commits at the ack edge
	logic [dtc_pkg::DIV_W-1:0] div_ff, nxt_div; // Free prescaler
	logic [dtc_pkg::LOWDIV_W-1:0] ldiv_ff, nxt_ldiv; // Low clock /8
	logic [2:0] s1_ff, s2_ff, s3_ff; // Sync stages, edge history
	logic [2:0] nxt_s1, nxt_s2, nxt_s3;
	logic low_tick, pin_a_tick, pin_b_tick;
	logic casc, slow, presel;
	logic run_a, run_b, tick_a, tick_b;
	logic roll_a; // Low byte carry; upper byte carry is not used
	logic [7:0] cnt_a, cnt_b;

	// ********************************
	// Wishbone slave
	// ********************************
	assign idx = wb_adr_in[7:2];
	assign wr_en = wb_cyc_in & wb_stb_in & wb_we_in & ack_ff & wb_sel_in[0];
	assign wb_ack_out = ack_ff;
	assign wb_dat_out = dat_ff;

	// Answer one cycle after the request; unmapped words read zero
	always_comb begin
		nxt_ack = wb_cyc_in & wb_stb_in & ~ack_ff;
		nxt_dat = dat_ff;
		if (nxt_ack) begin
			case (idx)
				dtc_pkg::IDX_CTL_A: nxt_dat = {24'h000000, ctl_a_ff};
				dtc_pkg::IDX_CTL_B: nxt_dat = {24'h000000, ctl_b_ff};
				dtc_pkg::IDX_PER_A: nxt_dat = {24'h000000, per_a_ff};
				dtc_pkg::IDX_PER_B: nxt_dat = {24'h000000, per_b_ff};
				dtc_pkg::IDX_WID_A: nxt_dat = {24'h000000, wid_a_ff};
				dtc_pkg::IDX_WID_B: nxt_dat = {24'h000000, wid_b_ff};
				dtc_pkg::IDX_CFG: nxt_dat = {30'h00000000, cfg_ff};
				dtc_pkg::IDX_STAT: nxt_dat = {16'h0000, cnt_b, cnt_a};
				default: nxt_dat = 32'h00000000;
			endcase
		end
	end

	// Register writes; software keeps fields stable while running
	always_comb begin
		nxt_ctl_a = ctl_a_ff;
		nxt_ctl_b = ctl_b_ff;
		nxt_per_a = per_a_ff;
		nxt_per_b = per_b_ff;
		nxt_wid_a = wid_a_ff;
		nxt_wid_b = wid_b_ff;
		nxt_cfg = cfg_ff;
		if (wr_en) begin
			case (idx)
				dtc_pkg::IDX_CTL_A: nxt_ctl_a = wb_dat_in[7:0];
				dtc_pkg::IDX_CTL_B: nxt_ctl_b = wb_dat_in[7:0];
				dtc_pkg::IDX_PER_A: nxt_per_a = wb_dat_in[7:0];
				dtc_pkg::IDX_PER_B: nxt_per_b = wb_dat_in[7:0];
				dtc_pkg::IDX_WID_A: nxt_wid_a = wb_dat_in[7:0];
				dtc_pkg::IDX_WID_B: nxt_wid_b = wb_dat_in[7:0];
				dtc_pkg::IDX_CFG: nxt_cfg = wb_dat_in[1:0];
				default: nxt_cfg = cfg_ff; // Unmapped write is dropped
			endcase
		end
	end

	// Register file and bus state
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			ctl_a_ff <= dtc_pkg::CTL_RST;
			ctl_b_ff <= dtc_pkg::CTL_RST;
			per_a_ff <= dtc_pkg::CMP_RST;
			per_b_ff <= dtc_pkg::CMP_RST;
			wid_a_ff <= dtc_pkg::CMP_RST;
			wid_b_ff <= dtc_pkg::CMP_RST;
			cfg_ff <= 2'h0;
			ack_ff <= 1'b0;
			dat_ff <= 32'h00000000;
		end else begin
			ctl_a_ff <= nxt_ctl_a;
			ctl_b_ff <= nxt_ctl_b;
			per_a_ff <= nxt_per_a;
			per_b_ff <= nxt_per_b;
			wid_a_ff <= nxt_wid_a;
			wid_b_ff <= nxt_wid_b;
			cfg_ff <= nxt_cfg;
			ack_ff <= nxt_ack;
			dat_ff <= nxt_dat;
		end
	end

	// ********************************
	// Prescaler and input synchronisers
	// ********************************
	// Bit order in the sync vectors: 0 low clock, 1 pin a, 2 pin b
	always_comb begin
		nxt_div = div_ff + 11'h001;
		nxt_s1 = {pin_b_in, pin_a_in, low_clk_in};
		nxt_s2 = s1_ff; // First stage feeds only the second
		nxt_s3 = s2_ff; // History for rising edge detection
		nxt_ldiv = low_tick ? ldiv_ff + 3'h1 : ldiv_ff;
	end

	// Rising edges of synchronised inputs, one pulse each
	assign low_tick = s2_ff[0] & ~s3_ff[0];
	assign pin_a_tick = s2_ff[1] & ~s3_ff[1];
	assign pin_b_tick = s2_ff[2] & ~s3_ff[2];

	// Prescaler and sync registers
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			div_ff <= '0;
			ldiv_ff <= '0;
			s1_ff <= 3'h0;
			s2_ff <= 3'h0;
			s3_ff <= 3'h0;
		end else begin
			div_ff <= nxt_div;
			ldiv_ff <= nxt_ldiv;
			s1_ff <= nxt_s1;
			s2_ff <= nxt_s2;
			s3_ff <= nxt_s3;
		end
	end

	// ********************************
	// Source clock selection
	// ********************************
	// Maps a clock code to a one-cycle tick; codes barred in slow mode
	// give no tick, so a misprogrammed counter simply stands still
	function automatic logic src_tick(input logic [2:0] sel, input logic pin,
			input logic warm);
		logic t;
		t = 1'b0;
		case (sel)
			dtc_pkg::CK_DIV11: begin
				if (slow || presel) begin
					t = low_tick & (&ldiv_ff);
				end else begin
					t = &div_ff[10:0];
				end
			end
			dtc_pkg::CK_DIV7: t = ~slow & (&div_ff[6:0]);
			dtc_pkg::CK_DIV5: t = ~slow & (&div_ff[4:0]);
			dtc_pkg::CK_DIV3: t = ~slow & (&div_ff[2:0]);
			dtc_pkg::CK_LOW: t = low_tick;
			dtc_pkg::CK_DIV1: t = ~slow & div_ff[0];
			dtc_pkg::CK_FULL: t = ~slow | warm;
			dtc_pkg::CK_PIN: t = pin;
			default: t = 1'b0;
		endcase
		return t;
	endfunction

	assign slow = cfg_ff[dtc_pkg::CFG_SLOW_BIT];
	assign presel = cfg_ff[dtc_pkg::CFG_PRESEL_BIT];

	// ********************************
	// Mode decode and cascade steering
	// ********************************
	// Cascade needs a at 011 and b in a 1xx mode; 011 in b is reserved
	assign casc = (ctl_a_ff.mode == dtc_pkg::MD_CASC) && ctl_b_ff.mode[2];
	assign run_a = casc ? ctl_b_ff.run : ctl_a_ff.run;
	assign run_b = ctl_b_ff.run;
	// Procedural so that prescaler state read inside the function wakes it;
	// a continuous assign would only follow the argument list
	always_comb begin
		tick_a = src_tick(ctl_a_ff.clk_sel, pin_a_tick,
			casc && ctl_b_ff.mode == dtc_pkg::MD_WARM);
	end

	// Upper byte ignores its own clock select; kept apart to avoid a self loop
	always_comb begin
		tick_b = casc ? roll_a : src_tick(ctl_b_ff.clk_sel, pin_b_tick, 1'b0);
	end

	// ********************************
	// Counters
	// ********************************
	dtc_count8 u_cnt_a (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.run_in(run_a),
		.tick_in(tick_a),
		.wrap_in(casc),
		.limit_in(per_a_ff),
		.ff_init_in(ctl_a_ff.ffc),
		.cnt_out(cnt_a),
		.roll_out(roll_a),
		.ff_out(ff_a_out)
	);

	// Counter b drives the pair's flop in cascade
	dtc_count8 u_cnt_b (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.run_in(run_b),
		.tick_in(tick_b),
		.wrap_in(1'b0),
		.limit_in(per_b_ff),
		.ff_init_in(ctl_b_ff.ffc),
		.cnt_out(cnt_b),
		.roll_out(),
		.ff_out(ff_b_out)
	);

	// ********************************
	// Assertions
	// ********************************
	logic first_ff; // High for the first edge after reset
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			first_ff <= 1'b1;
		end else begin
			first_ff <= 1'b0;
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	sequence s_req;
		wb_cyc_in && wb_stb_in && !ack_ff;
	endsequence
	sequence s_ans;
		ack_ff ##1 !ack_ff;
	endsequence

	property p_rst_cmp;
		first_ff |-> per_a_ff == 8'hff && per_b_ff == 8'hff && wid_a_ff == 8'hff && wid_b_ff == 8'hff;
	endproperty
	a_rst_cmp: assert property (p_rst_cmp) else $error("compare reset value wrong");

	property p_rst_ctl;
		first_ff |-> ctl_a_ff == 8'h00 && ctl_b_ff == 8'h00;
	endproperty
	a_rst_ctl: assert property (p_rst_ctl) else $error("control reset value wrong");

	property p_bus_ans;
		s_req |=> s_ans;
	endproperty
	a_bus_ans: assert property (p_bus_ans) else $error("bus answer not one cycle");

	property p_per_write;
		wr_en && idx == dtc_pkg::IDX_PER_B |=> per_b_ff == $past(wb_dat_in[7:0]);
	endproperty
	a_per_write: assert property (p_per_write) else $error("period write lost");

	property p_stop_clear;
		!run_a ##1 !run_a |-> cnt_a == 8'h00;
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("stopped counter not clear");

	property p_step;
		run_a && tick_a && !roll_a ##1 run_a |-> cnt_a == $past(cnt_a) + 8'h01;
	endproperty
	a_step: assert property (p_step) else $error("counter did not step");

	property p_upper;
		casc && run_b && cnt_b != $past(cnt_b) && cnt_b != 8'h00 |-> $past(roll_a);
	endproperty
	a_upper: assert property (p_upper) else $error("upper byte moved without carry");

	property p_casc_run;
		casc && !ctl_b_ff.run |=> cnt_a == 8'h00;
	endproperty
	a_casc_run: assert property (p_casc_run) else $error("cascade run not from b");

	property p_full_tick;
		!slow && ctl_a_ff.clk_sel == dtc_pkg::CK_FULL |-> tick_a;
	endproperty
	a_full_tick: assert property (p_full_tick) else $error("full rate tick missing");

	property p_slow_bar;
		slow && ctl_a_ff.clk_sel inside {3'h1, 3'h2, 3'h3, 3'h5} |-> !tick_a;
	endproperty
	a_slow_bar: assert property (p_slow_bar) else $error("barred code ticked in slow");

	property p_pin_sync;
		ctl_b_ff.clk_sel == dtc_pkg::CK_PIN && !casc && tick_b |-> $past(pin_b_in, 2);
	endproperty
	a_pin_sync: assert property (p_pin_sync) else $error("pin counted before sync");
endmodule // dtc_timer

// >>> verif/dtc_timer_tb.sv
`timescale 1ns/10ps
module dtc_timer_tb;
	// ****************
	// Signals
	// ****************
	logic mclk_in, rst_in, wb_cyc_in, wb_stb_in, wb_we_in, low_clk_in, pin_a_in, pin_b_in; // Bench-driven inputs
	logic [7:0] wb_adr_in; // Byte address
	logic [3:0] wb_sel_in; // Byte enables
	logic [31:0] wb_dat_in, wb_dat_out, rd; // Bus data
	logic wb_ack_out, ff_a_out, ff_b_out; // Design outputs
	int n_errors = 0;
	int num_checks = 0;
	typedef struct packed {logic [5:0] idx; logic [7:0] wd; logic [7:0] exp;} dtc_row_t;
	// Write then read back; unmapped index reads zero
	dtc_row_t rows [10] = '{
		'{dtc_pkg::IDX_PER_A, 8'h55, 8'h55}, '{dtc_pkg::IDX_PER_B, 8'haa, 8'haa},
		'{dtc_pkg::IDX_WID_A, 8'h0f, 8'h0f}, '{dtc_pkg::IDX_WID_B, 8'hf0, 8'hf0},
		'{dtc_pkg::IDX_CTL_A, 8'h01, 8'h01}, '{dtc_pkg::IDX_CTL_A, 8'h02, 8'h02},
		'{dtc_pkg::IDX_CTL_A, 8'h03, 8'h03}, '{dtc_pkg::IDX_CTL_B, 8'h04, 8'h04},
		'{dtc_pkg::IDX_CTL_B, 8'hd6, 8'hd6}, '{6'h20, 8'h5a, 8'h00}};
	dtc_timer dut (.mclk_in(mclk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
		.wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
		.wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .low_clk_in(low_clk_in), .pin_a_in(pin_a_in),
		.pin_b_in(pin_b_in), .ff_a_out(ff_a_out), .ff_b_out(ff_b_out));
	// ****************
	// Clock and watchdog
	// ****************
	initial begin
		mclk_in = 1'b0;
		forever #4 mclk_in = ~mclk_in;
	end
	// Whole run is about a thousand cycles; this limit leaves ample margin
	initial begin
		repeat (20000) @(posedge mclk_in);
		n_errors++;
		tally_and_finish();
	end
	// ****************
	// Tasks
	// ****************
	// One classic cycle; ack is sampled at the edge before its own update lands
	task automatic wb_xfer(input logic we, input logic [5:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge mclk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= we;
		wb_adr_in <= {idx, 2'b00};
		wb_sel_in <= 4'hf;
		wb_dat_in <= {24'h000000, wd};
		do begin
			@(posedge mclk_in);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 50);
		if (n >= 50) n_errors++;
		rd = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Read a register and compare the whole word against the zero-extended byte
	task automatic rd_chk(input string what, input logic [5:0] idx, input logic [7:0] exp);
		wb_xfer(1'b0, idx, 8'h00);
		chk(what, {24'h000000, exp}, rd);
	endtask
	// Rising edges on low clock (0) or a count pin (1, 2); slow enough for the synchronisers
	task automatic pulse(input int which, input int n);
		repeat (n) begin
			if (which == 0) low_clk_in <= 1'b1; else if (which == 1) pin_a_in <= 1'b1; else pin_b_in <= 1'b1;
			repeat (4) @(posedge mclk_in);
			low_clk_in <= 1'b0;
			pin_a_in <= 1'b0;
			pin_b_in <= 1'b0;
			repeat (4) @(posedge mclk_in);
		end
	endtask
	function automatic logic [7:0] ctl(input logic ff, input logic [2:0] ck, input logic run, input logic [2:0] md);
		return {ff, ck, run, md};
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ****************
	// Main sequence
	// ****************
	initial begin
		rst_in = 1'b1;
		{wb_cyc_in, wb_stb_in, wb_we_in, low_clk_in, pin_a_in, pin_b_in} = 6'h00;
		wb_adr_in = 8'h00;
		wb_sel_in = 4'h0;
		wb_dat_in = 32'h00000000;
		repeat (12) @(posedge mclk_in);
		rst_in <= 1'b0;
		// Table rows: stored values and mode codes read back
		foreach (rows[i]) begin
			wb_xfer(1'b1, rows[i].idx, rows[i].wd);
			rd_chk("row", rows[i].idx, rows[i].exp);
		end
		// Second reset in mid-run must restore both controls and all four compares
		@(posedge mclk_in);
		rst_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		rst_in <= 1'b0;
		rd_chk("ctl_a", dtc_pkg::IDX_CTL_A, 8'h00);
		rd_chk("ctl_b", dtc_pkg::IDX_CTL_B, 8'h00);
		for (int i = 0; i < 4; i++) begin
			rd_chk("cmp", dtc_pkg::IDX_PER_A + 6'(i), 8'hff);
		end
		chk("ff_a", 32'h0, {31'h0, ff_a_out});
		// Stopped flop follows control bit 7
		wb_xfer(1'b1, dtc_pkg::IDX_CTL_A, ctl(1'b1, 3'h0, 1'b0, dtc_pkg::MD_TIMER));
		wb_xfer(1'b1, dtc_pkg::IDX_CTL_B, ctl(1'b1, 3'h0, 1'b0, dtc_pkg::MD_TIMER));
		repeat (3) @(posedge mclk_in);
		chk("ff_a", 32'h1, {31'h0, ff_a_out});
		chk("ff_b", 32'h1, {31'h0, ff_b_out});
		// Pin counting on both counters, each with its own control
		wb_xfer(1'b1, dtc_pkg::IDX_CTL_A, ctl(1'b0, dtc_pkg::CK_PIN, 1'b1, dtc_pkg::MD_TIMER));
		pulse(1, 3);
		wb_xfer(1'b1, dtc_pkg::IDX_CTL_B, ctl(1'b0, dtc_pkg::CK_PIN, 1'b1, dtc_pkg::MD_TIMER));
		pulse(2, 2);
		wb_xfer(1'b0, dtc_pkg::IDX_STAT, 8'h00);
		chk("cnt_a", 32'h03, {24'h0, rd[7:0]});
		chk("cnt_b", 32'h02, {24'h0, rd[15:8]});
		// Stop clears the count
		wb_xfer(1'b1, dtc_pkg::IDX_CTL_A, ctl(1'b0, dtc_pkg::CK_PIN, 1'b0, dtc_pkg::MD_TIMER));
		wb_xfer(1'b1, dtc_pkg::IDX_CTL_B, ctl(1'b0, dtc_pkg::CK_PIN, 1'b0, dtc_pkg::MD_TIMER));
		rd_chk("stop", dtc_pkg::IDX_STAT, 8'h00);
		// Prescaler select at 1: code 000 is low clock divided by 8
		wb_xfer(1'b1, dtc_pkg::IDX_CFG, 8'h01);
		wb_xfer(1'b1, dtc_pkg::IDX_CTL_A, ctl(1'b0, dtc_pkg::CK_DIV11, 1'b1, dtc_pkg::MD_TIMER));
		pulse(0, 20);
		rd_chk("low_div8", dtc_pkg::IDX_STAT, 8'h02);
		wb_xfer(1'b1, dtc_pkg::IDX_CTL_A, ctl(1'b0, dtc_pkg::CK_DIV11, 1'b0, dtc_pkg::MD_TIMER));
		// Slow mode: fast prescaled code gives no tick, code 100 counts low clock
		wb_xfer(1'b1, dtc_pkg::IDX_CFG, 8'h02);
		wb_xfer(1'b1, dtc_pkg::IDX_CTL_A, ctl(1'b0, dtc_pkg::CK_DIV3, 1'b1, dtc_pkg::MD_TIMER));
		repeat (100) @(posedge mclk_in);
		rd_chk("slow_div3", dtc_pkg::IDX_STAT, 8'h00);
		wb_xfer(1'b1, dtc_pkg::IDX_CTL_A, ctl(1'b0, dtc_pkg::CK_DIV3, 1'b0, dtc_pkg::MD_TIMER));
		wb_xfer(1'b1, dtc_pkg::IDX_CTL_A, ctl(1'b0, dtc_pkg::CK_LOW, 1'b1, dtc_pkg::MD_TIMER));
		pulse(0, 5);
		rd_chk("slow_low", dtc_pkg::IDX_STAT, 8'h05);
		wb_xfer(1'b1, dtc_pkg::IDX_CTL_A, ctl(1'b0, dtc_pkg::CK_LOW, 1'b0, dtc_pkg::MD_TIMER));
		// Normal mode fast clock/8: about one count per 8 cycles from a cleared start
		wb_xfer(1'b1, dtc_pkg::IDX_CFG, 8'h00);
		wb_xfer(1'b1, dtc_pkg::IDX_CTL_A, ctl(1'b0, dtc_pkg::CK_DIV3, 1'b1, dtc_pkg::MD_TIMER));
		repeat (100) @(posedge mclk_in);
		wb_xfer(1'b0, dtc_pkg::IDX_STAT, 8'h00);
		chk("div3_range", 32'h1, {31'h0, (rd[7:0] >= 8'h0a && rd[7:0] <= 8'h10)});
		wb_xfer(1'b1, dtc_pkg::IDX_CTL_A, ctl(1'b0, dtc_pkg::CK_DIV3, 1'b0, dtc_pkg::MD_TIMER));
		// Cascade: clock from a's select, run from b; b counts a's carry; a's own run bit is ignored
		wb_xfer(1'b1, dtc_pkg::IDX_CTL_A, ctl(1'b0, dtc_pkg::CK_FULL, 1'b1, dtc_pkg::MD_CASC));
		wb_xfer(1'b1, dtc_pkg::IDX_CTL_B, ctl(1'b0, dtc_pkg::CK_PIN, 1'b1, dtc_pkg::MD_T16));
		repeat (300) @(posedge mclk_in);
		wb_xfer(1'b0, dtc_pkg::IDX_STAT, 8'h00);
		chk("casc_hi", 32'h01, {24'h0, rd[15:8]});
		// Stopping b stops the pair although a's run bit is still set
		wb_xfer(1'b1, dtc_pkg::IDX_CTL_B, ctl(1'b0, dtc_pkg::CK_PIN, 1'b0, dtc_pkg::MD_T16));
		rd_chk("casc_stop", dtc_pkg::IDX_STAT, 8'h00);
		tally_and_finish();
	end
endmodule // dtc_timer_tb
